/* File: src/fba_pkg.sv */
// Purpose: shared constants and carriers for the function block datapath
// Assumes: 50 MHz clock_in, one evaluation per task interval
// Notes:   Summary of operation heads the list below
//
// Summary of operation
// - ratio block, type 0x14: input times gain divided by denominator, two words
// - low word holds quotient bits 0..15, high word bits 16..31
// - quotient 0..65535 sits wholly in low word, high word is zero
// - negative quotient is two's complement over both words, bit 31 is sign
// - zero denominator gives zero in both result words
// - words form one signed 32-bit value; operands are signed 16-bit
// - low word is never saturated, so signed readers see wraparound
// - latch cell, type 0x16: reset wins, set alone sets, neither holds
// - latch second output is always the complement of the first
// - difference block, type 0x1b: a minus b, clamped to +/-32767
// - toggle cell, type 0x0b: flips on false-to-true clock input
// - toggle cell holds its outputs when no rising clock input is seen
// - sum block, type 0x1a: a plus b, clamped to +/-32767
// - every block is evaluated once per 20 ms task interval

package fba_pkg;

   // ---------------------------------------------------------------
   // block type codes
   // ---------------------------------------------------------------
   localparam logic [7:0] FBA_TYPE_NONE   = 8'h00;
   localparam logic [7:0] FBA_TYPE_RATIO  = 8'h14;
   localparam logic [7:0] FBA_TYPE_LATCH  = 8'h16;
   localparam logic [7:0] FBA_TYPE_DIFF   = 8'h1b;
   localparam logic [7:0] FBA_TYPE_TOGGLE = 8'h0b;
   localparam logic [7:0] FBA_TYPE_SUM    = 8'h1a;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int TASK_INTERVAL_MS = 20;
   localparam int CLOCK_HZ         = 50_000_000;
   localparam int TASK_CYCLES      = TASK_INTERVAL_MS * (CLOCK_HZ / 1000);

   // ---------------------------------------------------------------
   // limits and reset values
   // ---------------------------------------------------------------
   localparam logic signed [15:0] SAT_MAX    = 16'sh7fff;
   localparam logic signed [15:0] SAT_MIN    = 16'sh8001;
   localparam logic [15:0]        WORD_RESET = 16'h0000;
   localparam int                 WORD_W     = 16;
   localparam int                 DWORD_W    = 32;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic signed [15:0] operand;
      logic signed [15:0] gain;
      logic signed [15:0] denom;
   } fba_ratio_in_t;

   typedef struct packed {
      logic signed [15:0] a;
      logic signed [15:0] b;
   } fba_pair_t;

   typedef struct packed {
      logic primary;
      logic complement;
   } fba_logic_pair_t;

endpackage

/* File: src/fba_divider.sv */
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: divisor nonzero; start only while not busy
// Notes:   result after WIDTH cycles, remainder dropped (truncation)
`timescale 1ns/1ns

module fba_divider
#(
   parameter int WIDTH  = 32,
   parameter int DWIDTH = 16
)
(
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   input  wire logic              start_in,
   input  wire logic [WIDTH-1:0]  dividend_in,
   input  wire logic [DWIDTH-1:0] divisor_in,
   output logic                   done_out,
   output logic                   busy_out,
   output logic [WIDTH-1:0]       quotient_out
);

   localparam int CW = $clog2(WIDTH + 1);

   typedef struct packed {
      logic              busy;
      logic              done;
      logic [CW-1:0]     count;
      logic [DWIDTH:0]   rem;
      logic [DWIDTH-1:0] den;
      logic [WIDTH-1:0]  quo;
   } fba_div_state_t;

   fba_div_state_t s_q;
   fba_div_state_t s_d;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [DWIDTH:0] shifted;
      shifted = '0;
      s_d = s_q;
      s_d.done = 1'b0;
      if (start_in && !s_q.busy)
      begin
         s_d.busy  = 1'b1;
         s_d.count = CW'(WIDTH);
         s_d.rem   = '0;
         s_d.den   = divisor_in;
         s_d.quo   = dividend_in;
      end
      else if (s_q.busy)
      begin
         // shift one dividend bit into the partial remainder
         shifted = {s_q.rem[DWIDTH-1:0], s_q.quo[WIDTH-1]};
         if (shifted >= {1'b0, s_q.den})
         begin
            s_d.rem = shifted - {1'b0, s_q.den};
            s_d.quo = {s_q.quo[WIDTH-2:0], 1'b1};
         end
         else
         begin
            s_d.rem = shifted;
            s_d.quo = {s_q.quo[WIDTH-2:0], 1'b0};
         end
         s_d.count = s_q.count - CW'(1);
         if (s_q.count == CW'(1))
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign done_out     = s_q.done;
   assign busy_out     = s_q.busy;
   assign quotient_out = s_q.quo;

endmodule // fba_divider

/* File: src/fba_top.sv */
// Purpose: ratio, latch, toggle, difference and sum function blocks
// Assumes: all inputs come from logic on clock_in; no software registers
// Notes:   blocks sample their inputs on the task tick only
`timescale 1ns/1ns

module fba_top
#(
   parameter int TASK_CYCLES = fba_pkg::TASK_CYCLES
)
(
   input  wire logic                     clock_in,
   input  wire logic                     reset_in,
   input  wire fba_pkg::fba_ratio_in_t   ratio_in,
   input  wire logic [15:0]              latch_set_in,
   input  wire logic [15:0]              latch_reset_in,
   input  wire logic [15:0]              toggle_clock_in,
   input  wire fba_pkg::fba_pair_t       diff_in,
   input  wire fba_pkg::fba_pair_t       sum_in,
   output logic [15:0]                   low_result_word_out,
   output logic [15:0]                   high_result_word_out,
   output fba_pkg::fba_logic_pair_t      latch_cell_out,
   output fba_pkg::fba_logic_pair_t      toggle_cell_out,
   output logic signed [15:0]            diff_out,
   output logic signed [15:0]            sum_out,
   output logic [7:0]                    active_type_out,
   output logic                          eval_done_out
);

   typedef enum logic [0:0] {
      PH_IDLE,
      PH_DIVIDE
   } fba_phase_t;

   typedef struct packed {
      fba_phase_t               phase;
      logic [31:0]              timer;
      logic                     div_start;
      logic [31:0]              div_num;
      logic [15:0]              div_den;
      logic                     neg;
      logic [15:0]              lo;
      logic [15:0]              hi;
      fba_pkg::fba_logic_pair_t latch;
      fba_pkg::fba_logic_pair_t toggle;
      logic                     toggle_prev;
      logic signed [15:0]       diff;
      logic signed [15:0]       sum;
      logic [7:0]               active_type;
      logic                     eval_done;
   } fba_state_t;

   fba_state_t  s_q;
   fba_state_t  s_d;
   logic        div_done;
   logic        div_busy;
   logic [31:0] div_quo;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // word to logic level
   function automatic logic is_true(input logic [15:0] w);
      return |w;
   endfunction

   // clamp a 17-bit true result to the symmetric 16-bit limits +/-32767
   function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
      if (v > 17'(fba_pkg::SAT_MAX))
         return fba_pkg::SAT_MAX;
      else if (v < 17'(fba_pkg::SAT_MIN))
         return fba_pkg::SAT_MIN;
      else
         return v[15:0];
   endfunction

   // magnitude of a signed value as unsigned of the same width
   function automatic logic [31:0] mag32(input logic signed [31:0] v);
      return v[31] ? 32'(-v) : 32'(v);
   endfunction

   // ---------------------------------------------------------------
   // quotient divider
   // ---------------------------------------------------------------
   fba_divider
   #(
      .WIDTH  (fba_pkg::DWORD_W),
      .DWIDTH (fba_pkg::WORD_W)
   )
   u_divider
   (
      .clock_in     (clock_in),
      .reset_in     (reset_in),
      .start_in     (s_q.div_start),
      .dividend_in  (s_q.div_num),
      .divisor_in   (s_q.div_den),
      .done_out     (div_done),
      .busy_out     (div_busy),
      .quotient_out (div_quo)
   );

   // ---------------------------------------------------------------
   // evaluation sequence
   // ---------------------------------------------------------------
   always_comb
   begin
      logic              tick;
      logic              set_t;
      logic              rst_t;
      logic              clk_t;
      logic signed [31:0] product;
      logic [31:0]       signed_q;
      logic [15:0]       den_mag;
      tick     = 1'b0;
      set_t    = 1'b0;
      rst_t    = 1'b0;
      clk_t    = 1'b0;
      product  = '0;
      signed_q = '0;
      den_mag  = '0;
      s_d = s_q;
      s_d.div_start = 1'b0;
      s_d.eval_done = 1'b0;

      // task interval timer
      if (s_q.timer >= 32'(TASK_CYCLES - 1))
      begin
         s_d.timer = '0;
         tick = 1'b1;
      end
      else
      begin
         s_d.timer = s_q.timer + 32'h0000_0001;
      end

      case (s_q.phase)
         PH_IDLE:
         begin
            s_d.active_type = fba_pkg::FBA_TYPE_NONE;
            if (tick && !div_busy)
            begin
               // latch cell: reset has priority
               set_t = is_true(latch_set_in);
               rst_t = is_true(latch_reset_in);
               if (rst_t)
                  s_d.latch.primary = 1'b0;
               else if (set_t)
                  s_d.latch.primary = 1'b1;
               s_d.latch.complement = ~s_d.latch.primary;

               // toggle cell: rising level between evaluations
               clk_t = is_true(toggle_clock_in);
               if (clk_t && !s_q.toggle_prev)
                  s_d.toggle.primary = ~s_q.toggle.primary;
               s_d.toggle.complement = ~s_d.toggle.primary;
               s_d.toggle_prev = clk_t;

               // saturating difference and sum
               s_d.diff = sat16(17'(diff_in.a) - 17'(diff_in.b));
               s_d.sum  = sat16(17'(sum_in.a) + 17'(sum_in.b));

               // ratio block: full product before division
               product = 32'(ratio_in.operand) * 32'(ratio_in.gain);
               den_mag = ratio_in.denom[15] ? 16'(-ratio_in.denom)
                                            : 16'(ratio_in.denom);
               if (ratio_in.denom == 16'sh0000)
               begin
                  s_d.lo = fba_pkg::WORD_RESET;
                  s_d.hi = fba_pkg::WORD_RESET;
                  s_d.eval_done = 1'b1;
               end
               else
               begin
                  s_d.div_num   = mag32(product);
                  s_d.div_den   = den_mag;
                  s_d.neg       = product[31] ^ ratio_in.denom[15];
                  s_d.div_start = 1'b1;
                  s_d.phase     = PH_DIVIDE;
                  s_d.active_type = fba_pkg::FBA_TYPE_RATIO;
               end
            end
         end
         PH_DIVIDE:
         begin
            s_d.active_type = fba_pkg::FBA_TYPE_RATIO;
            if (div_done)
            begin
               // magnitude quotient is truncated, sign applied after
               signed_q = s_q.neg ? 32'(-div_quo) : div_quo;
               s_d.lo = signed_q[15:0];
               s_d.hi = signed_q[31:16];
               s_d.phase = PH_IDLE;
               s_d.active_type = fba_pkg::FBA_TYPE_NONE;
               s_d.eval_done = 1'b1;
            end
         end
         default:
         begin
            s_d.phase = PH_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         s_q <= '0;
         s_q.phase <= PH_IDLE;
         s_q.latch.complement <= 1'b1;
         s_q.toggle.complement <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign low_result_word_out  = s_q.lo;
   assign high_result_word_out = s_q.hi;
   assign latch_cell_out       = s_q.latch;
   assign toggle_cell_out      = s_q.toggle;
   assign diff_out             = s_q.diff;
   assign sum_out              = s_q.sum;
   assign active_type_out      = s_q.active_type;
   assign eval_done_out        = s_q.eval_done;

endmodule // fba_top

/* File: testbench/fba_top_properties.sv */
// Purpose: port-level checks for the function block datapath
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to fba_top by bind at the foot of this file
`timescale 1ns/1ns

module fba_top_properties
#(
   parameter int TASK_CYCLES = fba_pkg::TASK_CYCLES
)
(
   input wire logic                     clock_in,
   input wire logic                     reset_in,
   input wire fba_pkg::fba_ratio_in_t   ratio_in,
   input wire logic [15:0]              latch_set_in,
   input wire logic [15:0]              latch_reset_in,
   input wire logic [15:0]              toggle_clock_in,
   input wire logic [15:0]              low_result_word_out,
   input wire logic [15:0]              high_result_word_out,
   input wire fba_pkg::fba_logic_pair_t latch_cell_out,
   input wire fba_pkg::fba_logic_pair_t toggle_cell_out,
   input wire logic signed [15:0]       diff_out,
   input wire logic signed [15:0]       sum_out,
   input wire logic [7:0]               active_type_out,
   input wire logic                     eval_done_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);

   // ---------------------------------------------------------------
   // evaluation timing
   // ---------------------------------------------------------------
   property p_done_pulse;
      eval_done_out |=> !eval_done_out;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
   property p_div_span;
      $rose(active_type_out == fba_pkg::FBA_TYPE_RATIO) |->
         (active_type_out == fba_pkg::FBA_TYPE_RATIO)[*8] ##27
         (eval_done_out && active_type_out == 8'h00);
   endproperty
   a_div_span: assert property (p_div_span) else $error("ratio result late");
   property p_div_start;
      $rose(active_type_out == fba_pkg::FBA_TYPE_RATIO) |-> $past(ratio_in.denom) != 16'h0000;
   endproperty
   a_div_start: assert property (p_div_start) else $error("divide by zero started");
   property p_zero_div;
      eval_done_out && $past(active_type_out) == 8'h00 |->
         low_result_word_out == 16'h0000 && high_result_word_out == 16'h0000;
   endproperty
   a_zero_div: assert property (p_zero_div) else $error("zero divisor result");
   property p_word_stable;
      !$past(reset_in) && $changed({high_result_word_out, low_result_word_out})
         |-> eval_done_out;
   endproperty
   a_word_stable: assert property (p_word_stable) else $error("result moved");

   // ---------------------------------------------------------------
   // logic cells and clamps
   // ---------------------------------------------------------------
   property p_latch_comp;
      latch_cell_out.complement == !latch_cell_out.primary;
   endproperty
   a_latch_comp: assert property (p_latch_comp) else $error("latch complement");
   property p_latch_rise;
      !$past(reset_in) && $rose(latch_cell_out.primary) |->
         $past(latch_set_in) != 16'h0000 && $past(latch_reset_in) == 16'h0000;
   endproperty
   a_latch_rise: assert property (p_latch_rise) else $error("latch set wrongly");
   property p_latch_fall;
      !$past(reset_in) && $fell(latch_cell_out.primary) |-> $past(latch_reset_in) != 16'h0000;
   endproperty
   a_latch_fall: assert property (p_latch_fall) else $error("latch cleared wrongly");
   property p_toggle_comp;
      toggle_cell_out.complement == !toggle_cell_out.primary;
   endproperty
   a_toggle_comp: assert property (p_toggle_comp) else $error("toggle complement");
   property p_toggle_hold;
      !$past(reset_in) && $changed(toggle_cell_out.primary) |-> $past(toggle_clock_in) != 16'h0000;
   endproperty
   a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved");
   property p_sat_range;
      diff_out != 16'sh8000 && sum_out != 16'sh8000;
   endproperty
   a_sat_range: assert property (p_sat_range) else $error("clamp range");
endmodule // fba_top_properties

bind fba_top fba_top_properties #(.TASK_CYCLES(TASK_CYCLES)) fba_top_properties_inst (
   .clock_in(clock_in), .reset_in(reset_in), .ratio_in(ratio_in),
   .latch_set_in(latch_set_in), .latch_reset_in(latch_reset_in),
   .toggle_clock_in(toggle_clock_in), .low_result_word_out(low_result_word_out),
   .high_result_word_out(high_result_word_out), .latch_cell_out(latch_cell_out),
   .toggle_cell_out(toggle_cell_out), .diff_out(diff_out), .sum_out(sum_out),
   .active_type_out(active_type_out), .eval_done_out(eval_done_out));

/* File: testbench/fba_top_tb.sv */
// Purpose: self-checking bench for the function block datapath
// Assumes: short task interval of 40 cycles
// Notes:   inputs change right after each completed evaluation
`timescale 1ns/1ns

module fba_top_tb;
   localparam int TC = 40;
   logic                     clock_in = 1'b0;
   logic                     reset_in = 1'b1;
   fba_pkg::fba_ratio_in_t   ratio_in = '0;
   logic [15:0]              latch_set_in = 16'h0000;
   logic [15:0]              latch_reset_in = 16'h0000;
   logic [15:0]              toggle_clock_in = 16'h0000;
   fba_pkg::fba_pair_t       diff_in = '0;
   fba_pkg::fba_pair_t       sum_in = '0;
   logic [15:0]              low_result_word_out;
   logic [15:0]              high_result_word_out;
   fba_pkg::fba_logic_pair_t latch_cell_out;
   fba_pkg::fba_logic_pair_t toggle_cell_out;
   logic signed [15:0]       diff_out;
   logic signed [15:0]       sum_out;
   logic [7:0]               active_type_out;
   logic                     eval_done_out;
   int                       failures = 0;
   int                       n_compared = 0;

   // clock
   always #10 clock_in = ~clock_in;

   fba_top #(.TASK_CYCLES(TC)) fba_top_inst (
      .clock_in(clock_in), .reset_in(reset_in), .ratio_in(ratio_in),
      .latch_set_in(latch_set_in), .latch_reset_in(latch_reset_in),
      .toggle_clock_in(toggle_clock_in), .diff_in(diff_in), .sum_in(sum_in),
      .low_result_word_out(low_result_word_out), .high_result_word_out(high_result_word_out),
      .latch_cell_out(latch_cell_out), .toggle_cell_out(toggle_cell_out),
      .diff_out(diff_out), .sum_out(sum_out), .active_type_out(active_type_out),
      .eval_done_out(eval_done_out));

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // wait for the next completed evaluation
   task automatic eval_wait();
      int n;
      n = 0;
      @(posedge clock_in);
      while (eval_done_out !== 1'b1 && n < 200)
      begin
         @(posedge clock_in);
         n++;
      end
      if (n >= 200)
      begin
         failures++;
         summarize();
      end
   endtask

   function automatic logic [15:0] clamp(input int v);
      return (v > 32767) ? 16'h7fff : (v < -32767) ? 16'h8001 : 16'(v);
   endfunction

   // ratio block with signs, truncation, wide and zero divisor cases
   task automatic t_ratio();
      int    tv [8][3] = '{'{32767, 32767, 1}, '{56, 128, 10}, '{-2, 16383, 1},
                           '{16385, 2, 1}, '{5, 7, 0}, '{-7, 1, 2}, '{7, -1, 2},
                           '{-32767, -32767, -1}};
      longint q;
      for (int i = 0; i < 8; i++)
      begin
         ratio_in.operand <= 16'(tv[i][0]);
         ratio_in.gain <= 16'(tv[i][1]);
         ratio_in.denom <= 16'(tv[i][2]);
         eval_wait();
         q = (tv[i][2] == 0) ? 0 : (longint'(tv[i][0]) * tv[i][1]) / tv[i][2];
         check({high_result_word_out, low_result_word_out}, 32'(q));
      end
      $display("ratio test done");
   endtask

   // latch cell: set, hold, reset, both, nonzero words as true
   task automatic t_latch();
      logic [15:0] s [6] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0002};
      logic [15:0] r [6] = '{16'h0000, 16'h0000, 16'h0100, 16'h0000, 16'hffff, 16'h0000};
      logic        e [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++)
      begin
         latch_set_in <= s[i];
         latch_reset_in <= r[i];
         eval_wait();
         check({30'h0, latch_cell_out}, {30'h0, e[i], ~e[i]});
      end
      $display("latch test done");
   endtask

   // toggle cell: flips only on a false-to-true change between evaluations
   task automatic t_toggle();
      logic [15:0] v [7] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0002, 16'h0000, 16'h0004};
      logic        st;
      logic        prev;
      st = 1'b0;
      prev = 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         toggle_clock_in <= v[i];
         eval_wait();
         if (!prev && v[i] != 16'h0000)
            st = ~st;
         prev = (v[i] != 16'h0000);
         check({30'h0, toggle_cell_out}, {30'h0, st, ~st});
      end
      $display("toggle test done");
   endtask

   // difference and sum blocks at and beyond the limits
   task automatic t_clamp();
      int tv [8][2] = '{'{10, 15}, '{-32765, 2}, '{-5, -23}, '{32767, -32767},
                        '{-32767, 32767}, '{1, 2}, '{32767, 4}, '{-32767, -10}};
      for (int i = 0; i < 8; i++)
      begin
         diff_in <= {16'(tv[i][0]), 16'(tv[i][1])};
         sum_in <= {16'(tv[i][0]), 16'(tv[i][1])};
         eval_wait();
         check({16'h0, diff_out}, {16'h0, clamp(tv[i][0] - tv[i][1])});
         check({16'h0, sum_out}, {16'h0, clamp(tv[i][0] + tv[i][1])});
      end
      $display("clamp test done");
   endtask

   // mid-run reset: cells and words return to idle, next evaluation works again
   task automatic t_reset();
      reset_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      reset_in <= 1'b0;
      @(posedge clock_in);
      check({28'h0, latch_cell_out, toggle_cell_out}, 32'h0000_0005);
      check({high_result_word_out, low_result_word_out}, 32'h0000_0000);
      eval_wait();
      check({28'h0, latch_cell_out, toggle_cell_out}, 32'h0000_000a);
      check({high_result_word_out, low_result_word_out}, 32'hc000_ffff);
      $display("reset test done");
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (5) @(posedge clock_in);
      reset_in <= 1'b0;
      t_ratio();
      t_latch();
      t_toggle();
      t_clamp();
      t_reset();
      summarize();
   end

   // watchdog
   initial
   begin
      repeat (5000) @(posedge clock_in);
      failures++;
      summarize();
   end
endmodule // fba_top_tb
